// [hw/asb_consts.svh]
// register offsets, field positions and receiver timing counts for the serial block
`ifndef ASB_CONSTS_SVH
`define ASB_CONSTS_SVH

`define ASB_ADDR_W          8
`define ASB_OFF_STATUS_ONE  8'h10
`define ASB_OFF_CONTROL     8'h14
`define ASB_OFF_DATA_BUF    8'h18
`define ASB_OFF_STATUS_TWO  8'h1c
`define ASB_OFF_BAUD_SEL    8'h20

`define ASB_S1_TX_EMPTY     7
`define ASB_S1_RX_FULL      5
`define ASB_S1_FRAME_ERR    1
`define ASB_S2_BREAK        1
`define ASB_S2_RX_BUSY      0
`define ASB_CT_NINE_BIT     0
`define ASB_CT_RX_EN        1
`define ASB_CT_TX_EN        2
`define ASB_BR_PRE_LSB      4
`define ASB_BR_RATE_LSB     0

`define ASB_CONTROL_RST     3'h0
`define ASB_PRESCALE_RST    2'h0
`define ASB_RATE_RST        3'h0

`define ASB_SLOT_FIRST      5'h01
`define ASB_SLOT_SAMPLE     5'h08
`define ASB_SLOT_LAST       5'h10
`define ASB_IDLE_SLOTS      8'ha0
`define ASB_TX_FRAME_BITS   4'ha
`define ASB_TX_PHASE_LAST   4'hf

`endif

// [hw/asb_pkg.sv]
// types shared by the serial block
package asb_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA  = 4'b0100,
      ST_STOP  = 4'b1000
   } asb_rx_state_type;
endpackage

// [hw/asb_baud_gen.sv]
// baud generator: prescaler and rate divisor giving the receiver sample tick
`timescale 1ns/1ns
module asb_baud_gen
   import asb_pkg::*;
(
   input  wire logic       pclk,          // bus clock, also the crystal rate
   input  wire logic       presetn,       // async reset, active low
   input  wire logic [1:0] prescale_sel,  // prescale_select field
   input  wire logic [2:0] rate_sel,      // rate_divisor_select field
   output logic            rt_tick        // one pulse per sample slot
);
   logic [5:0] pre_cnt_q;
   logic [6:0] rate_cnt_q;
   logic       rt_tick_q;
   logic [5:0] pre_lim;
   logic [7:0] rate_full;
   logic [6:0] rate_lim;
   logic       pre_tick;
   logic       rate_wrap;

   // slot rate is crystal / (4 * pd * bd), i.e. sixteen slots per bit
   assign pre_lim   = (prescale_sel == 2'h0) ? 6'h03 :
                      (prescale_sel == 2'h1) ? 6'h0b :
                      (prescale_sel == 2'h2) ? 6'h0f : 6'h33;
   assign rate_full = 8'(8'h01 << rate_sel);
   assign rate_lim  = 7'(rate_full - 8'h01);
   assign pre_tick  = (pre_cnt_q >= pre_lim);
   assign rate_wrap = (rate_cnt_q >= rate_lim);
   assign rt_tick   = rt_tick_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_q  <= 6'h00;
         rate_cnt_q <= 7'h00;
         rt_tick_q  <= 1'b0;
      end else begin
         pre_cnt_q  <= pre_tick ? 6'h00 : 6'(pre_cnt_q + 6'h01);
         if (pre_tick) begin
            rate_cnt_q <= rate_wrap ? 7'h00 : 7'(rate_cnt_q + 7'h01);
         end
         rt_tick_q  <= pre_tick && rate_wrap;
      end
   end

   property p_tick_spacing;
      @(posedge pclk) disable iff (!presetn)
      rt_tick_q |=> !rt_tick_q [*3];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("slot tick too fast");
endmodule // asb_baud_gen

// [hw/asb_top.sv]
// serial block: status two flags, data buffer, baud select, receiver and transmitter
`timescale 1ns/1ns
`include "asb_consts.svh"
module asb_top
   import asb_pkg::*;
(
   input  wire logic        pclk,     // bus clock, 10 MHz
   input  wire logic        presetn,  // async reset, active low
   input  wire logic        psel,     // apb select
   input  wire logic        penable,  // apb access phase
   input  wire logic        pwrite,   // apb direction
   input  wire logic [7:0]  paddr,    // apb byte address
   input  wire logic [31:0] pwdata,   // apb write data
   output logic      [31:0] prdata,   // apb read data
   output logic             pready,   // apb ready
   output logic             pslverr,  // apb error, unmapped address
   input  wire logic        rxd,      // serial receive pin
   output logic             txd       // serial transmit pin
);
   asb_rx_state_type st_q, st_d;
   logic        rx_meta_q, rx_sync_q;
   logic [4:0]  slot_q, slot_d;
   logic [3:0]  bit_q, bit_d;
   logic [8:0]  rx_shift_q, rx_shift_d;
   logic [7:0]  idle_cnt_q, idle_cnt_d;
   logic [7:0]  rx_data_q, tx_buf_q;
   logic        ninth_q;
   logic [2:0]  control_q;
   logic [1:0]  prescale_q;
   logic [2:0]  rate_q;
   logic        bkf_q, fe_q, rf_q, rpf_q, armed_q;
   logic        bk_arm_q, fe_arm_q, rf_arm_q;
   logic        tx_full_q;
   logic [9:0]  tx_shift_q;
   logic [3:0]  tx_left_q, tx_phase_q;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q, txd_q;
   logic        rt_tick;
   logic        rpf_set, rpf_clr, frame_done, false_start;

   // bus decode
   logic        setup, done, rd_done, wr_done;
   logic        hit_s1, hit_ct, hit_db, hit_s2, hit_br, hit_any;
   logic        rd_s1, rd_s2, rd_db, wr_db, wr_ct, wr_br;
   logic [7:0]  status_one, status_two, baud_val, rd_mux;
   assign setup   = psel && !penable;
   assign done    = psel && penable && pready_q;
   assign rd_done = done && !pwrite;
   assign wr_done = done && pwrite;
   assign hit_s1  = (paddr == `ASB_OFF_STATUS_ONE);
   assign hit_ct  = (paddr == `ASB_OFF_CONTROL);
   assign hit_db  = (paddr == `ASB_OFF_DATA_BUF);
   assign hit_s2  = (paddr == `ASB_OFF_STATUS_TWO);
   assign hit_br  = (paddr == `ASB_OFF_BAUD_SEL);
   assign hit_any = hit_s1 || hit_ct || hit_db || hit_s2 || hit_br;
   assign rd_s1   = rd_done && hit_s1;
   assign rd_s2   = rd_done && hit_s2;
   assign rd_db   = rd_done && hit_db;
   assign wr_db   = wr_done && hit_db;
   assign wr_ct   = wr_done && hit_ct;
   assign wr_br   = wr_done && hit_br;

   // no interrupt path exists for break or in-progress flags
   assign status_one = {!tx_full_q, 1'b0, rf_q, 3'h0, fe_q, 1'b0};
   assign status_two = {6'h00, bkf_q, rpf_q};
   assign baud_val   = {2'h0, prescale_q, 1'b0, rate_q};
   assign rd_mux     = hit_s1 ? status_one :
                       hit_ct ? {5'h00, control_q} :
                       hit_db ? rx_data_q :
                       hit_s2 ? status_two :
                       hit_br ? baud_val : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !hit_any;
         if (setup && !pwrite) begin
            prdata_q <= {24'h000000, rd_mux};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q  <= `ASB_CONTROL_RST;
         prescale_q <= `ASB_PRESCALE_RST;
         rate_q     <= `ASB_RATE_RST;
      end else begin
         if (wr_ct) begin
            control_q <= pwdata[2:0];
         end
         if (wr_br) begin
            prescale_q <= pwdata[`ASB_BR_PRE_LSB +: 2];
            rate_q     <= pwdata[`ASB_BR_RATE_LSB +: 3];
         end
      end
   end

   // one slot tick drives both directions
   asb_baud_gen u_baud (
      .pclk         (pclk),
      .presetn      (presetn),
      .prescale_sel (prescale_q),
      .rate_sel     (rate_q),
      .rt_tick      (rt_tick)
   );

   // receive pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= rxd;
         rx_sync_q <= rx_meta_q;
      end
   end

   logic       nine_bit, rx_en, tx_en;
   logic [3:0] last_bit;
   logic [7:0] rx_word;
   logic       all_zero, break_seen;
   assign nine_bit   = control_q[`ASB_CT_NINE_BIT];
   assign rx_en      = control_q[`ASB_CT_RX_EN];
   assign tx_en      = control_q[`ASB_CT_TX_EN];
   assign last_bit   = nine_bit ? 4'h8 : 4'h7;
   assign rx_word    = nine_bit ? rx_shift_q[7:0] : rx_shift_q[8:1];
   assign all_zero   = nine_bit ? (rx_shift_q == 9'h000) : (rx_shift_q[8:1] == 8'h00);
   assign break_seen = frame_done && all_zero && !rx_sync_q;

   // receiver sequencing, advanced once per sample slot
   always_comb begin
      st_d        = st_q;
      slot_d      = slot_q;
      bit_d       = bit_q;
      rx_shift_d  = rx_shift_q;
      idle_cnt_d  = idle_cnt_q;
      rpf_set     = 1'b0;
      rpf_clr     = 1'b0;
      frame_done  = 1'b0;
      false_start = 1'b0;
      if (rt_tick) begin
         slot_d = 5'(slot_q + 5'h01);
         unique case (st_q)
            ST_IDLE: begin
               if (rx_en && !rx_sync_q) begin
                  st_d       = ST_START;
                  slot_d     = `ASB_SLOT_FIRST;
                  rpf_set    = 1'b1;
                  idle_cnt_d = 8'h00;
               end else if (rx_sync_q) begin
                  if (idle_cnt_q == `ASB_IDLE_SLOTS) begin
                     rpf_clr = 1'b1;
                  end else begin
                     idle_cnt_d = 8'(idle_cnt_q + 8'h01);
                  end
               end else begin
                  idle_cnt_d = 8'h00;
               end
            end
            ST_START: begin
               if (slot_q == `ASB_SLOT_SAMPLE && rx_sync_q) begin
                  st_d        = ST_IDLE;
                  false_start = 1'b1;
                  rpf_clr     = 1'b1;
               end else if (slot_q == `ASB_SLOT_LAST) begin
                  st_d   = ST_DATA;
                  slot_d = `ASB_SLOT_FIRST;
                  bit_d  = 4'h0;
               end
            end
            ST_DATA: begin
               if (slot_q == `ASB_SLOT_SAMPLE) begin
                  rx_shift_d = {rx_sync_q, rx_shift_q[8:1]};
               end
               if (slot_q == `ASB_SLOT_LAST) begin
                  slot_d = `ASB_SLOT_FIRST;
                  if (bit_q == last_bit) begin
                     st_d = ST_STOP;
                  end else begin
                     bit_d = 4'(bit_q + 4'h1);
                  end
               end
            end
            ST_STOP: begin
               if (slot_q == `ASB_SLOT_SAMPLE) begin
                  frame_done = 1'b1;
                  st_d       = ST_IDLE;
                  idle_cnt_d = 8'h00;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q       <= ST_IDLE;
         slot_q     <= `ASB_SLOT_FIRST;
         bit_q      <= 4'h0;
         rx_shift_q <= 9'h000;
         idle_cnt_q <= 8'h00;
      end else begin
         st_q       <= st_d;
         slot_q     <= slot_d;
         bit_q      <= bit_d;
         rx_shift_q <= rx_shift_d;
         idle_cnt_q <= idle_cnt_d;
      end
   end

   // buffer contents survive reset
   always_ff @(posedge pclk) begin
      if (frame_done) begin
         rx_data_q <= rx_word;
         ninth_q   <= break_seen ? 1'b0 : rx_shift_q[8];
      end
      if (wr_db) begin
         tx_buf_q <= pwdata[7:0];
      end
   end

   // flags: a set in the clearing cycle wins
   logic bk_set, fe_set, rf_set;
   assign bk_set = break_seen && armed_q;
   assign fe_set = frame_done && !rx_sync_q;
   assign rf_set = frame_done;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bkf_q    <= 1'b0;
         fe_q     <= 1'b0;
         rf_q     <= 1'b0;
         rpf_q    <= 1'b0;
         armed_q  <= 1'b1;
         bk_arm_q <= 1'b0;
         fe_arm_q <= 1'b0;
         rf_arm_q <= 1'b0;
      end else begin
         bkf_q    <= bk_set || (bkf_q && !(rd_db && bk_arm_q));
         fe_q     <= fe_set || bk_set || (fe_q && !(rd_db && fe_arm_q));
         rf_q     <= rf_set || (rf_q && !(rd_db && rf_arm_q));
         rpf_q    <= rpf_set || (rpf_q && !rpf_clr);
         armed_q  <= (rx_sync_q && st_q == ST_IDLE) || (armed_q && !bk_set);
         bk_arm_q <= rd_s2 ? bkf_q : (bk_arm_q && !rd_db);
         fe_arm_q <= rd_s1 ? fe_q : (fe_arm_q && !rd_db);
         rf_arm_q <= rd_s1 ? rf_q : (rf_arm_q && !rd_db);
      end
   end

   // transmitter: start, eight data bits, stop, one bit per sixteen slots
   logic tx_bit_edge, tx_load;
   assign tx_bit_edge = rt_tick && (tx_phase_q == `ASB_TX_PHASE_LAST);
   assign tx_load     = tx_bit_edge && (tx_left_q == 4'h0) && tx_full_q && tx_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_full_q  <= 1'b0;
         tx_shift_q <= 10'h3ff;
         tx_left_q  <= 4'h0;
         tx_phase_q <= 4'h0;
         txd_q      <= 1'b1;
      end else begin
         tx_full_q <= wr_db || (tx_full_q && !tx_load);
         if (rt_tick) begin
            tx_phase_q <= 4'(tx_phase_q + 4'h1);
         end
         if (tx_load) begin
            txd_q      <= 1'b0;
            tx_shift_q <= {2'h3, tx_buf_q};
            tx_left_q  <= 4'(`ASB_TX_FRAME_BITS - 4'h1);
         end else if (tx_bit_edge && tx_left_q != 4'h0) begin
            txd_q      <= tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            tx_left_q  <= 4'(tx_left_q - 4'h1);
         end else if (tx_bit_edge) begin
            txd_q <= 1'b1;
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign txd     = txd_q;

   // status two read with break set, and no data read since
   logic clr_pend_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_pend_q <= 1'b0;
      end else begin
         clr_pend_q <= (rd_s2 && bkf_q) || (clr_pend_q && !rd_db);
      end
   end

   sequence s_status_two_read_set;
      rd_s2 && bkf_q;
   endsequence
   sequence s_data_read;
      rd_db && !bk_set && clr_pend_q;
   endsequence

   property p_break_sets_others;
      @(posedge pclk) disable iff (!presetn)
      $rose(bkf_q) |-> fe_q && rf_q;
   endproperty
   a_break_sets_others: assert property (p_break_sets_others) else $error("break without fe/rf");

   property p_break_ninth;
      @(posedge pclk) disable iff (!presetn)
      frame_done && break_seen |=> !ninth_q;
   endproperty
   a_break_ninth: assert property (p_break_ninth) else $error("ninth bit kept on break");

   property p_break_clear;
      @(posedge pclk) disable iff (!presetn)
      s_status_two_read_set ##[1:8] s_data_read |=> !bkf_q;
   endproperty
   a_break_clear: assert property (p_break_clear) else $error("break not cleared");

   property p_break_only_by_read;
      @(posedge pclk) disable iff (!presetn)
      $fell(bkf_q) |-> $past(rd_db && bk_arm_q);
   endproperty
   a_break_only_by_read: assert property (p_break_only_by_read) else $error("break fell alone");

   property p_break_rearm;
      @(posedge pclk) disable iff (!presetn)
      $rose(bkf_q) |-> $past(armed_q);
   endproperty
   a_break_rearm: assert property (p_break_rearm) else $error("break set while disarmed");

   property p_rpf_set;
      @(posedge pclk) disable iff (!presetn)
      rt_tick && st_q == ST_IDLE && rx_en && !rx_sync_q |=> rpf_q && st_q == ST_START;
   endproperty
   a_rpf_set: assert property (p_rpf_set) else $error("in-progress not set");

   property p_rpf_false_start;
      @(posedge pclk) disable iff (!presetn)
      false_start |=> !rpf_q && st_q == ST_IDLE;
   endproperty
   a_rpf_false_start: assert property (p_rpf_false_start) else $error("in-progress kept");

   property p_rx_full;
      @(posedge pclk) disable iff (!presetn)
      frame_done |=> rf_q && rx_data_q == $past(rx_word);
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("receiver full not set");

   property p_frame_err;
      @(posedge pclk) disable iff (!presetn)
      frame_done && !rx_sync_q |=> fe_q;
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("framing error missed");

   property p_apb_answer;
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready_q ##1 !pready_q;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");
endmodule // asb_top

// [verification/asb_remote_peer.sv]
// remote serial peer: drives the receive line and captures the transmit line
`timescale 1ns/1ns
module asb_remote_peer (
   input  wire logic pclk, // bus clock
   output logic      rxd,  // line into the block, idle high
   input  wire logic txd   // line out of the block
);
   initial rxd = 1'b1;

   // start, eight bits lsb first, stop; a zero stop leaves the line low
   task automatic send(input logic [7:0] d, input logic stop, input int bl);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (bl) @(posedge pclk);
      end
   endtask

   task automatic hold(input logic v, input int n);
      rxd <= v;
      repeat (n) @(posedge pclk);
   endtask

   // samples each bit in its middle; ok stays low without start or good stop
   task automatic take(output logic [7:0] d, output logic ok, input int bl);
      int k;
      k = 0;
      ok = 1'b0;
      d = 8'h00;
      while (txd !== 1'b0 && k < 20000) begin
         k++;
         @(posedge pclk);
      end
      if (k < 20000) begin
         repeat (bl / 2) @(posedge pclk);
         for (int i = 0; i < 8; i++) begin
            repeat (bl) @(posedge pclk);
            d[i] = txd;
         end
         repeat (bl) @(posedge pclk);
         ok = (txd === 1'b1);
      end
   endtask
endmodule // asb_remote_peer

// [verification/tb_async_serial_status_data_baud.sv]
// testbench for the serial block: registers, receiver flags, transmitter, baud
`timescale 1ns/1ns
`include "asb_consts.svh"
module tb_async_serial_status_data_baud;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, e, ok;
   logic [7:0]  paddr, d8;
   logic [31:0] pwdata, prdata, q;
   int          n_fail, tests_run;
   int          pd_tab [4] = '{1, 3, 4, 13};
   localparam int BL = 64; // pclk per bit at baud select zero

   asb_top asb_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd)
   );
   asb_remote_peer asb_remote_peer_i (.pclk(pclk), .rxd(rxd), .txd(txd));

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         n_fail++;
         close_out();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(nm, q & m, exp);
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   task automatic t_reset();
      rc("status two", `ASB_OFF_STATUS_TWO, 32'hffffffff, 32'h0);
      rc("baud select", `ASB_OFF_BAUD_SEL, 32'hffffffff, 32'h0);
      rc("status one", `ASB_OFF_STATUS_ONE, 32'h22, 32'h0);
      apb(8'h04, 1'b0, 32'h0);
      chk("unmapped err", 32'(e), 32'h1);
      apb(`ASB_OFF_STATUS_TWO, 1'b1, 32'hff);
      rc("status two write", `ASB_OFF_STATUS_TWO, 32'hffffffff, 32'h0);
   endtask

   task automatic t_rx();
      apb(`ASB_OFF_CONTROL, 1'b1, 32'h6);
      fork
         asb_remote_peer_i.send(8'ha5, 1'b1, BL);
         begin
            repeat (3 * BL) @(posedge pclk);
            rc("in progress", `ASB_OFF_STATUS_TWO, 32'h1, 32'h1);
         end
      join
      rc("rx full", `ASB_OFF_STATUS_ONE, 32'h22, 32'h20);
      rc("rx data", `ASB_OFF_DATA_BUF, 32'hffffffff, 32'ha5);
      rc("rx full clear", `ASB_OFF_STATUS_ONE, 32'h20, 32'h0);
      rc("busy after frame", `ASB_OFF_STATUS_TWO, 32'h1, 32'h1);
      repeat (12 * BL) @(posedge pclk);
      // the in-progress flag is polled before the receiver is switched off
      rc("idle clears", `ASB_OFF_STATUS_TWO, 32'h1, 32'h0);
      apb(`ASB_OFF_CONTROL, 1'b1, 32'h0);
      do_reset();
      rc("data kept", `ASB_OFF_DATA_BUF, 32'hffffffff, 32'ha5);
   endtask

   task automatic t_ferr();
      apb(`ASB_OFF_CONTROL, 1'b1, 32'h6);
      asb_remote_peer_i.send(8'h3c, 1'b0, BL);
      asb_remote_peer_i.hold(1'b1, BL);
      rc("frame err", `ASB_OFF_STATUS_ONE, 32'h22, 32'h22);
      rc("no break", `ASB_OFF_STATUS_TWO, 32'h2, 32'h0);
      rc("ferr data", `ASB_OFF_DATA_BUF, 32'hffffffff, 32'h3c);
   endtask

   task automatic t_break();
      asb_remote_peer_i.send(8'h00, 1'b0, BL);
      rc("break fe rf", `ASB_OFF_STATUS_ONE, 32'h22, 32'h22);
      rc("break data", `ASB_OFF_DATA_BUF, 32'hffffffff, 32'h0);
      rc("break kept", `ASB_OFF_STATUS_TWO, 32'h2, 32'h2);
      rc("break read", `ASB_OFF_DATA_BUF, 32'hffffffff, 32'h0);
      rc("break clear", `ASB_OFF_STATUS_TWO, 32'h2, 32'h0);
      asb_remote_peer_i.hold(1'b0, 12 * BL);
      rc("no rearm low", `ASB_OFF_STATUS_TWO, 32'h2, 32'h0);
      asb_remote_peer_i.hold(1'b1, 12 * BL);
      asb_remote_peer_i.send(8'h00, 1'b0, BL);
      asb_remote_peer_i.hold(1'b1, BL);
      rc("rearmed", `ASB_OFF_STATUS_TWO, 32'h2, 32'h2);
      apb(`ASB_OFF_DATA_BUF, 1'b0, 32'h0);
      // nine-bit mode: a zero ninth bit with a good stop is no break
      apb(`ASB_OFF_CONTROL, 1'b1, 32'h7);
      asb_remote_peer_i.hold(1'b1, 12 * BL);
      asb_remote_peer_i.send(8'h00, 1'b0, BL);
      asb_remote_peer_i.hold(1'b1, BL);
      rc("nine-bit no break", `ASB_OFF_STATUS_TWO, 32'h2, 32'h0);
      asb_remote_peer_i.send(8'h00, 1'b0, BL);
      asb_remote_peer_i.hold(1'b0, BL);
      asb_remote_peer_i.hold(1'b1, BL);
      rc("nine-bit break", `ASB_OFF_STATUS_TWO, 32'h2, 32'h2);
      rc("nine-bit data", `ASB_OFF_DATA_BUF, 32'hffffffff, 32'h0);
      apb(`ASB_OFF_CONTROL, 1'b1, 32'h6);
   endtask

   task automatic t_false();
      asb_remote_peer_i.hold(1'b1, 12 * BL);
      fork
         asb_remote_peer_i.hold(1'b0, 16);
         begin
            repeat (10) @(posedge pclk);
            rc("glitch set", `ASB_OFF_STATUS_TWO, 32'h1, 32'h1);
         end
      join
      asb_remote_peer_i.hold(1'b1, 4 * BL);
      rc("false start", `ASB_OFF_STATUS_TWO, 32'h1, 32'h0);
   endtask

   task automatic t_tx();
      apb(`ASB_OFF_BAUD_SEL, 1'b1, 32'h11);
      fork
         asb_remote_peer_i.send(8'hc3, 1'b1, 384);
         begin
            apb(`ASB_OFF_DATA_BUF, 1'b1, 32'h5a);
            asb_remote_peer_i.take(d8, ok, 384);
         end
      join
      chk("tx byte", 32'(d8), 32'h5a);
      chk("tx frame", 32'(ok), 32'h1);
      rc("rx at same rate", `ASB_OFF_DATA_BUF, 32'hffffffff, 32'hc3);
   endtask

   task automatic baud_case(input logic [1:0] p, input logic [2:0] r);
      int k, n, len;
      len = 64 * pd_tab[p] * (1 << r);
      do_reset();
      apb(`ASB_OFF_BAUD_SEL, 1'b1, {26'h0, p, 1'b0, r});
      rc("baud readback", `ASB_OFF_BAUD_SEL, 32'hff, {26'h0, p, 1'b0, r});
      apb(`ASB_OFF_CONTROL, 1'b1, 32'h4);
      apb(`ASB_OFF_DATA_BUF, 1'b1, 32'hff);
      k = 0;
      while (txd !== 1'b0 && k < 3 * len + 100) begin
         k++;
         @(posedge pclk);
      end
      n = 0;
      while (txd === 1'b0 && n < 3 * len) begin
         n++;
         @(posedge pclk);
      end
      chk("start bit length", n, len);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_fail = 0;
      tests_run = 0;
      do_reset();
      t_reset();
      t_rx();
      t_ferr();
      t_break();
      t_false();
      t_tx();
      for (int p = 0; p < 4; p++) baud_case(2'(p), 3'h0);
      for (int r = 1; r < 8; r++) baud_case(2'h0, 3'(r));
      do_reset();
      close_out();
   end
endmodule // tb_async_serial_status_data_baud
